/* cur_out_pkg.sv */
// constants for the four-channel current output word port
package cur_out_pkg;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned DATA_LSB = 0;
  localparam int unsigned SEL_LSB = 16;
  localparam int unsigned SEL_W = 2;
  localparam int unsigned OE_BIT = 31;
  localparam int unsigned NUM_CH = 4;
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam logic [15:0] CODE_4MA = 16'h0000;
  localparam logic [15:0] CODE_20MA = 16'hFFFF;
endpackage

/* cur_out_if.sv */
// interface from the word decoder to one channel holding register
`timescale 1ns/10ps
`default_nettype none
interface cur_out_if;
  logic wr;
  logic clr;
  logic [15:0] data;
  logic [15:0] code;
  modport ctrl (output wr, output clr, output data, input code);
  modport chan (input wr, input clr, input data, output code);
endinterface
`default_nettype wire

/* cur_out_chan.sv */
// one channel holding register
`timescale 1ns/10ps
`default_nettype none
module cur_out_chan
  import cur_out_pkg::*;
(
  // clock, reset and clock enable
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // port to the decoder
  cur_out_if.chan port
);
  logic [15:0] code_r;
  logic [15:0] code_nxt;

  always_comb
  begin
    code_nxt = code_r;
    if (port.clr)
      code_nxt = CODE_RESET;
    else if (port.wr)
      code_nxt = port.data;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      code_r <= CODE_RESET;
    else if (ce_i)
      code_r <= code_nxt;
  end

  assign port.code = code_r;

  a_clr_zero: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && port.clr |=> code_r == CODE_RESET)
    else $error("holding register not cleared");
  a_hold_code: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !(ce_i && (port.clr || port.wr)) |=> $stable(code_r))
    else $error("holding register changed without write");
endmodule // cur_out_chan
`default_nettype wire

/* cur_out_port.sv */
// top: host output word decoder and four channel converter codes
`timescale 1ns/10ps
`default_nettype none
module cur_out_port
  import cur_out_pkg::*;
(
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // host output points
  input wire logic [31:0] out_word_i,
  input wire logic word_wr_i,
  // converter codes, 0 = 4mA, FFFF = 20mA
  output logic [15:0] dac_code0_o,
  output logic [15:0] dac_code1_o,
  output logic [15:0] dac_code2_o,
  output logic [15:0] dac_code3_o,
  // status
  output logic out_en_o
);
  // word fields
  logic [15:0] data_f;
  logic [1:0] sel_f;
  logic oe_f;
  assign data_f = out_word_i[DATA_LSB +: DATA_W];
  assign sel_f = out_word_i[SEL_LSB +: SEL_W];
  assign oe_f = out_word_i[OE_BIT];

  logic oe_r;
  logic oe_nxt;
  logic [15:0] code_r [NUM_CH];
  logic [15:0] code_nxt [NUM_CH];
  logic [15:0] hold [NUM_CH];

  // enable tracks the most recent host word
  always_comb
  begin
    oe_nxt = oe_r;
    if (word_wr_i)
      oe_nxt = oe_f;
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      cur_out_if cif ();
      assign cif.clr = word_wr_i && !oe_f;
      assign cif.wr = word_wr_i && oe_f &&
        (sel_f == 2'(g));
      assign cif.data = data_f;
      assign hold[g] = cif.code;
      cur_out_chan u_chan (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .port(cif.ctrl)
      );
      // cleared holding register reads zero, which is 4mA
      always_comb
      begin
        code_nxt[g] = hold[g];
        if (!oe_r)
          code_nxt[g] = CODE_4MA;
      end
      always_ff @(posedge core_clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
          code_r[g] <= CODE_4MA;
        else if (ce_i)
          code_r[g] <= code_nxt[g];
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      oe_r <= 1'b0;
    else if (ce_i)
      oe_r <= oe_nxt;
  end

  assign dac_code0_o = code_r[0];
  assign dac_code1_o = code_r[1];
  assign dac_code2_o = code_r[2];
  assign dac_code3_o = code_r[3];
  assign out_en_o = oe_r;

  a_oe_off_4ma: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && !oe_r |=> dac_code0_o == CODE_4MA && dac_code3_o == CODE_4MA)
    else $error("output not at 4mA while disabled");
  a_write_lands: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && sel_f == 2'b10 ##1 ce_i && oe_r
    |=> dac_code2_o == $past(out_word_i[15:0], 2))
    else $error("selected channel not updated");
  a_other_kept: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && oe_r && sel_f != 2'b00 ##1 ce_i
    |=> $stable(dac_code0_o))
    else $error("unselected channel changed");
  a_enable_track: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && word_wr_i |=> out_en_o == $past(out_word_i[31]))
    else $error("enable bit not followed");
  a_rise_4ma: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && word_wr_i && !oe_f ##1 ce_i && !word_wr_i ##1 ce_i && !word_wr_i
    |=> dac_code1_o == CODE_4MA)
    else $error("channel left 4mA without a write");
  a_ce_freeze: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !ce_i |=> $stable(out_en_o) && $stable(dac_code3_o))
    else $error("state moved with clock enable low");
  a_data_lsb: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && sel_f == 2'b01 ##1 ce_i && oe_r
    |=> dac_code1_o[0] == $past(out_word_i[0], 2))
    else $error("data bit 0 misplaced");
  a_full_scale: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && sel_f == 2'b11 && out_word_i[15:0] ==
    CODE_20MA ##1 ce_i && oe_r |=> dac_code3_o == CODE_20MA)
    else $error("full scale code lost");

  // edges seen with the outputs disabled, saturating at seven
  logic [2:0] off_cnt_r;
  logic [2:0] off_cnt_nxt;

  always_comb
  begin
    off_cnt_nxt = off_cnt_r;
    if (oe_r)
      off_cnt_nxt = 3'h0;
    else if (off_cnt_r != 3'h7)
      off_cnt_nxt = off_cnt_r + 3'h1;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      off_cnt_r <= 3'h0;
    else if (ce_i)
      off_cnt_r <= off_cnt_nxt;
  end

  a_off_settled: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    off_cnt_r != 3'h0 |-> dac_code0_o == CODE_4MA &&
    dac_code1_o == CODE_4MA && dac_code2_o == CODE_4MA &&
    dac_code3_o == CODE_4MA)
    else $error("outputs not at 4mA after disable");
  a_off_ch1: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && !oe_r |=> dac_code1_o == CODE_4MA)
    else $error("channel two not at 4mA while disabled");
  a_off_ch2: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && !oe_r |=> dac_code2_o == CODE_4MA)
    else $error("channel three not at 4mA while disabled");

  // a write reaches its own channel two edges later
  a_land_ch0: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && sel_f == 2'b00 ##1 ce_i && oe_r
    |=> dac_code0_o == $past(out_word_i[15:0], 2))
    else $error("channel one not updated");
  a_land_ch1: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && sel_f == 2'b01 ##1 ce_i && oe_r
    |=> dac_code1_o == $past(out_word_i[15:0], 2))
    else $error("channel two not updated");
  a_land_ch3: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && sel_f == 2'b11 ##1 ce_i && oe_r
    |=> dac_code3_o == $past(out_word_i[15:0], 2))
    else $error("channel four not updated");

  // a write to one channel leaves the others alone
  a_keep_ch1: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && oe_r && sel_f != 2'b01 ##1 ce_i
    |=> $stable(dac_code1_o))
    else $error("channel two changed by another write");
  a_keep_ch2: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && oe_r && sel_f != 2'b10 ##1 ce_i
    |=> $stable(dac_code2_o))
    else $error("channel three changed by another write");
  a_keep_ch3: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && oe_r && sel_f != 2'b11 ##1 ce_i
    |=> $stable(dac_code3_o))
    else $error("channel four changed by another write");

  // bit weights of the data field
  a_lsb_ch0: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && sel_f == 2'b00 ##1 ce_i && oe_r
    |=> dac_code0_o[0] == $past(out_word_i[0], 2))
    else $error("channel one bit 0 misplaced");
  a_lsb_ch2: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && sel_f == 2'b10 ##1 ce_i && oe_r
    |=> dac_code2_o[0] == $past(out_word_i[0], 2))
    else $error("channel three bit 0 misplaced");
  a_lsb_ch3: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && sel_f == 2'b11 ##1 ce_i && oe_r
    |=> dac_code3_o[0] == $past(out_word_i[0], 2))
    else $error("channel four bit 0 misplaced");
  a_msb_ch0: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && sel_f == 2'b00 ##1 ce_i && oe_r
    |=> dac_code0_o[15] == $past(out_word_i[15], 2))
    else $error("channel one bit 15 misplaced");
  a_msb_ch1: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && sel_f == 2'b01 ##1 ce_i && oe_r
    |=> dac_code1_o[15] == $past(out_word_i[15], 2))
    else $error("channel two bit 15 misplaced");
  a_msb_ch2: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && sel_f == 2'b10 ##1 ce_i && oe_r
    |=> dac_code2_o[15] == $past(out_word_i[15], 2))
    else $error("channel three bit 15 misplaced");
  a_msb_ch3: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && sel_f == 2'b11 ##1 ce_i && oe_r
    |=> dac_code3_o[15] == $past(out_word_i[15], 2))
    else $error("channel four bit 15 misplaced");

  // full scale reaches every channel unchanged
  a_full_ch0: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && sel_f == 2'b00 && out_word_i[15:0] ==
    CODE_20MA ##1 ce_i && oe_r |=> dac_code0_o == CODE_20MA)
    else $error("channel one full scale lost");
  a_full_ch1: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && sel_f == 2'b01 && out_word_i[15:0] ==
    CODE_20MA ##1 ce_i && oe_r |=> dac_code1_o == CODE_20MA)
    else $error("channel two full scale lost");
  a_full_ch2: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && sel_f == 2'b10 && out_word_i[15:0] ==
    CODE_20MA ##1 ce_i && oe_r |=> dac_code2_o == CODE_20MA)
    else $error("channel three full scale lost");

  // a zero code keeps the channel at 4mA
  a_zero_ch0: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && sel_f == 2'b00 && out_word_i[15:0] ==
    16'h0000 ##1 ce_i && oe_r |=> dac_code0_o == CODE_4MA)
    else $error("channel one left 4mA on zero code");
  a_zero_ch1: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && sel_f == 2'b01 && out_word_i[15:0] ==
    16'h0000 ##1 ce_i && oe_r |=> dac_code1_o == CODE_4MA)
    else $error("channel two left 4mA on zero code");
  a_zero_ch2: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && sel_f == 2'b10 && out_word_i[15:0] ==
    16'h0000 ##1 ce_i && oe_r |=> dac_code2_o == CODE_4MA)
    else $error("channel three left 4mA on zero code");
  a_zero_ch3: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f && sel_f == 2'b11 && out_word_i[15:0] ==
    16'h0000 ##1 ce_i && oe_r |=> dac_code3_o == CODE_4MA)
    else $error("channel four left 4mA on zero code");

  // cleared channels stay at 4mA until written
  a_rise_ch0: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && !oe_f ##1 ce_i && !word_wr_i ##1 ce_i &&
    !word_wr_i |=> dac_code0_o == CODE_4MA)
    else $error("channel one left 4mA without a write");
  a_rise_ch2: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && !oe_f ##1 ce_i && !word_wr_i ##1 ce_i &&
    !word_wr_i |=> dac_code2_o == CODE_4MA)
    else $error("channel three left 4mA without a write");
  a_rise_ch3: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && !oe_f ##1 ce_i && !word_wr_i ##1 ce_i &&
    !word_wr_i |=> dac_code3_o == CODE_4MA)
    else $error("channel four left 4mA without a write");
  a_other_ch3: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && !oe_f ##1 ce_i && word_wr_i && oe_f &&
    sel_f == 2'b00 ##1 ce_i |=> dac_code3_o == CODE_4MA)
    else $error("channel four left 4mA on another write");
  a_other_ch2: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && !oe_f ##1 ce_i && word_wr_i && oe_f &&
    sel_f == 2'b11 ##1 ce_i |=> dac_code2_o == CODE_4MA)
    else $error("channel three left 4mA on another write");
  a_clear_all: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && !oe_f ##1 ce_i |=> dac_code0_o == CODE_4MA &&
    dac_code1_o == CODE_4MA && dac_code2_o == CODE_4MA &&
    dac_code3_o == CODE_4MA)
    else $error("clear word left a channel driven");

  // enable status and clock enable
  a_en_low: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && !oe_f |=> !out_en_o)
    else $error("enable not cleared by word");
  a_en_high: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && word_wr_i && oe_f |=> out_en_o)
    else $error("enable not set by word");
  a_en_idle: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && !word_wr_i |=> $stable(out_en_o))
    else $error("enable moved without a word");
  a_ce_codes: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    !ce_i |=> $stable(dac_code0_o) && $stable(dac_code1_o) &&
    $stable(dac_code2_o))
    else $error("codes moved with clock enable low");
  a_hold_out: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    ce_i && !word_wr_i && oe_r ##1 ce_i && !word_wr_i
    |=> $stable(dac_code0_o) && $stable(dac_code1_o) &&
    $stable(dac_code2_o) && $stable(dac_code3_o))
    else $error("code changed without a write");

  c_back_to_back: cover property (@(posedge core_clk_i)
    ce_i && word_wr_i ##1 ce_i && word_wr_i);
  c_settled: cover property (@(posedge core_clk_i) off_cnt_r == 3'h7);
  c_write: cover property (@(posedge core_clk_i) ce_i && word_wr_i && oe_f);
  c_disable: cover property (@(posedge core_clk_i) ce_i && word_wr_i && !oe_f);
  c_rise: cover property (@(posedge core_clk_i) $rose(out_en_o));
endmodule // cur_out_port
`default_nettype wire

/* cur_out_host.sv */
// host controller model writing output words
`timescale 1ns/10ps
`default_nettype none
module cur_out_host
(
  // clock
  input wire logic core_clk_i,
  // output points
  output logic [31:0] out_word_o,
  output logic word_wr_o
);
  initial
  begin
    out_word_o = 32'h00000000;
    word_wr_o = 1'b0;
  end
  // unused points set high to show they are ignored
  task automatic send(input logic [1:0] ch, input logic [15:0] code,
                      input logic en);
    @(posedge core_clk_i);
    #2;
    out_word_o = {en, 13'h1FFF, ch, code};
    word_wr_o = 1'b1;
    @(posedge core_clk_i);
    #2;
    word_wr_o = 1'b0;
    out_word_o = ~out_word_o;
  endtask
endmodule // cur_out_host
`default_nettype wire

/* quad_current_output_word_port_bench.sv */
// self-checking bench for the current output word port
`timescale 1ns/10ps
`default_nettype none
module quad_current_output_word_port_bench;
  logic clk, rstn, ce, wr, oe;
  logic [31:0] word;
  logic [15:0] c0, c1, c2, c3;
  logic [15:0] exp [4];
  logic [64:0] seen;
  int err_count = 0;
  int checked = 0;
  assign seen = {oe, c3, c2, c1, c0};
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  cur_out_host host (.core_clk_i(clk), .out_word_o(word), .word_wr_o(wr));
  cur_out_port DUT (.core_clk_i(clk), .rstn_i(rstn), .ce_i(ce),
    .out_word_i(word), .word_wr_i(wr), .dac_code0_o(c0), .dac_code1_o(c1),
    .dac_code2_o(c2), .dac_code3_o(c3), .out_en_o(oe));
  function automatic logic [64:0] want(input logic en);
    return {en, exp[3], exp[2], exp[1], exp[0]};
  endfunction
  task automatic chk(input logic [64:0] got, input logic [64:0] w);
    checked++;
    if (got !== w)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, got, w);
    end
  endtask
  // write one word and wait for the code to reach the outputs
  task automatic put(input logic [1:0] ch, input logic [15:0] v,
                     input logic en);
    host.send(ch, v, en);
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic t_select();
    logic [15:0] tab [4];
    tab = '{16'h1234, 16'hFFFF, 16'h8000, 16'h0001};
    for (int i = 3; i >= 0; i--)
    begin
      put(i[1:0], tab[i], 1'b1);
      exp[i] = tab[i];
      chk(seen, want(1'b1));
    end
  endtask
  task automatic t_disable();
    put(2'd1, 16'h7777, 1'b0);
    exp = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    chk(seen, want(1'b0));
  endtask
  task automatic t_reenable();
    put(2'd0, 16'h0000, 1'b1);
    chk(seen, want(1'b1));
    put(2'd1, 16'h4321, 1'b1);
    exp[1] = 16'h4321;
    chk(seen, want(1'b1));
  endtask
  task automatic t_freeze();
    ce = 1'b0;
    put(2'd2, 16'hBEEF, 1'b1);
    chk(seen, want(1'b1));
    ce = 1'b1;
  endtask
  task automatic print_verdict();
    $display("errors=%0d checks=%0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_count++;
    print_verdict();
  end
  initial
  begin
    rstn = 1'b0;
    ce = 1'b1;
    exp = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    repeat (6) @(posedge clk);
    #2;
    rstn = 1'b1;
    chk(seen, want(1'b0));
    t_select();
    t_disable();
    t_reenable();
    t_freeze();
    print_verdict();
  end
endmodule // quad_current_output_word_port_bench
`default_nettype wire
